// [bench/asp_remote.sv]
// Remote serial partner: frame sender and frame catcher
`timescale 1ns/1ps
module asp_remote #(
	parameter int BIT_CLKS = 8
) (
	// Clock
	input  wire logic pclk,
	// Frame format, high for nine data bits
	input  wire logic nine,
	// Serial lines
	output logic      to_dut,
	input  wire logic from_dut
);
	int rx_q[$];  // Caught frames, raw bits LSB first
	int v;        // Frame being caught
	initial to_dut = 1'b1;  // Idle high
	// Hold the line for one bit time
	task automatic hold_bit(input logic b);
		to_dut <= b;
		repeat (BIT_CLKS) @(posedge pclk);
	endtask
	// Send start, data LSB first, ninth or stop, then idle
	task automatic send(input logic [7:0] d, input logic b9);
		int i;
		hold_bit(1'b0);  // Start low
		for (i = 0; i < 8; i++) begin
			hold_bit(d[i]);  // LSB first
		end
		hold_bit(b9);  // Ninth bit, or stop in 8-bit mode
		hold_bit(1'b1);  // Stop or idle high
		if (nine) begin
			hold_bit(1'b1);  // Idle after nine-bit frame
		end
	endtask
	// Catch frames from the design, sampling mid bit
	always begin
		@(negedge from_dut);
		repeat (BIT_CLKS / 2) @(posedge pclk);
		v = 0;
		for (int k = 0; k < (nine ? 10 : 9); k++) begin
			repeat (BIT_CLKS) @(posedge pclk);
			v[k] = from_dut;
		end
		rx_q.push_back(v);
	end
endmodule

// [bench/test_asp_uart.sv]
// Self-checking bench for the serial port against a remote partner
`timescale 1ns/1ps
module test_asp_uart;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, r;
	logic        rx_line, tx_line, irq, nine, e;
	logic [7:0]  d;
	logic [1:0]  ext_div = 2'h0;  // Count input source, one rise per four clocks
	int          miscompares, compares, seed, i, m, n, mdat, mrb8, mflag, acc;
	// Receive table: enable, mode, filter, ninth or stop, clear flag
	int ren_t[7] = '{0, 1, 1, 1, 1, 1, 1};
	int mod_t[7] = '{0, 0, 0, 0, 1, 1, 1};
	int mce_t[7] = '{0, 1, 0, 1, 1, 1, 0};  // Filter set, cleared after a match
	int b9_t[7]  = '{1, 1, 1, 0, 0, 1, 0};
	int clr_t[7] = '{1, 1, 0, 1, 1, 1, 1};
	// Design and partner
	asp_uart asp_uart_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .serial_rx_line(rx_line), .serial_tx_line(tx_line),
		.ext_osc_in(1'b0), .external_count_input(ext_div[1]), .uart_irq(irq));
	// Count input pulses for the external timer clock
	always @(posedge pclk) ext_div <= ext_div + 2'h1;
	asp_remote asp_remote_inst (.pclk(pclk), .nine(nine), .to_dut(rx_line), .from_dut(tx_line));
	// Clock, 4 ns period
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	// Counts and verdict
	task automatic print_verdict();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// Compare seen against expected
	task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
		compares++;
		if (seen !== want) begin
			miscompares++;
			$display("CHECK FAILED at %0t: %s seen %h want %h", $time, what, seen, want);
		end
	endtask
	// One APB transfer, bounded wait for pready
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			miscompares++;
			print_verdict();
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	// Bounded wait for the interrupt level
	task automatic wait_irq(input logic lvl);
		n = 0;
		while (irq !== lvl && n < 2000) begin
			@(posedge pclk);
			n++;
		end
		if (n >= 2000) begin
			miscompares++;
			print_verdict();
		end
	endtask
	// Main sequence
	initial begin
		{psel, penable, pwrite, paddr, pwdata, nine} = '0;
		{miscompares, compares, mdat, mrb8, mflag} = '0;
		seed = 69;
		presetn = 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, asp_pkg::ADDR_CTRL, 32'h0);
		check(r, 32'h0000_0040, "ctrl reset");
		check(tx_line, 1'b1, "tx idle");
		apb(1'b0, 8'h10, 32'h0);
		check(e, 1'b1, "unmapped");
		// Interrupt on, timer on, clock /4, reload FF: 8 pclk bits
		apb(1'b1, asp_pkg::ADDR_CFG, 32'h0000_FF03);
		// Transmit one frame in each mode, ninth bit set
		// Third frame: 8-bit, timer clocked by the count input
		for (m = 0; m < 3; m++) begin
			nine <= m[0];
			if (m == 2) apb(1'b1, asp_pkg::ADDR_CFG, 32'h0000_FF13);
			apb(1'b1, asp_pkg::ADDR_CTRL, {24'h0, m[0], 7'h08});
			d = $random(seed);
			apb(1'b1, asp_pkg::ADDR_DATA, {24'h0, d});
			apb(1'b0, asp_pkg::ADDR_STAT, 32'h0);
			check(r, 32'h1, "tx busy");
			apb(1'b0, asp_pkg::ADDR_DATA, 32'h0);
			check(r, mdat, "data reads receive side");
			wait_irq(1'b1);
			check(asp_remote_inst.rx_q.size(), 0, "done before stop ends");
			repeat (4 * 8) @(posedge pclk);
			check(asp_remote_inst.rx_q.size(), 1, "frame caught");
			check(asp_remote_inst.rx_q.pop_front(), (m[0] ? 32'h300 : 32'h100) | d, "tx frame");
			apb(1'b0, asp_pkg::ADDR_CTRL, 32'h0);
			check(r[1], 1'b1, "tx flag stays");
			apb(1'b1, asp_pkg::ADDR_CTRL, 32'h0);
			wait_irq(1'b0);
		end
		// Receive table: enable, filters, overrun
		for (i = 0; i < 7; i++) begin
			if (clr_t[i] != 0) mflag = 0;
			acc = (ren_t[i] != 0 && mflag == 0 && (mce_t[i] == 0 || b9_t[i] != 0)) ? 1 : 0;
			nine <= mod_t[i][0];
			apb(1'b1, asp_pkg::ADDR_CTRL, (mod_t[i] << 7) | (mce_t[i] << 5) | (ren_t[i] << 4) | (mrb8 << 2) | mflag);
			d = $random(seed);
			asp_remote_inst.send(d, b9_t[i][0]);
			repeat (2) @(posedge pclk);
			if (acc != 0) begin
				mdat = d;
				mrb8 = b9_t[i];
				mflag = 1;
			end
			apb(1'b0, asp_pkg::ADDR_DATA, 32'h0);
			check(r, mdat, "rx buffer");
			apb(1'b0, asp_pkg::ADDR_CTRL, 32'h0);
			check(r, 32'h40 | (mod_t[i] << 7) | (mce_t[i] << 5) | (ren_t[i] << 4) | (mrb8 << 2) | mflag,
				"rx ctrl");
			check(irq, mflag[0], "irq level");
		end
		print_verdict();
	end
endmodule

// [hdl/asp_baud_timer.sv]
// Transmit timer and private receive timer with halving
`timescale 1ns/1ps
module asp_baud_timer (
	// Clock and reset
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	// Configuration and timer clock
	input  wire asp_pkg::asp_baud_cfg_t cfg,
	input  wire logic                   tick,
	input  wire logic                   rx_restart,
	// Bit rate pulses
	output logic                        tx_bit,
	output logic                        rx_bit
);
	// Channel 0 transmits, channel 1 receives
	typedef struct packed {
		logic [1:0][7:0] cnt;   // Low byte counters
		logic [1:0]      half;  // Overflow halvers
		logic [1:0]      bit_p; // Registered bit pulses
	} asp_bt_st_t;
	asp_bt_st_t st_reg, st_next;

	// Counting, reloading and halving per channel
	always_comb begin
		st_next = st_reg;
		st_next.bit_p = 2'b00;
		for (int ch = 0; ch < 2; ch++) begin
			if (ch == 1 && rx_restart) begin
				// Start seen: realign receive timing
				st_next.cnt[ch] = cfg.reload;
				st_next.half[ch] = 1'b0;
			end else if (cfg.timer_en && tick) begin
				// Both counters share one reload byte
				if (st_reg.cnt[ch] == asp_pkg::TMR_TOP) begin
					st_next.cnt[ch] = cfg.reload;
					st_next.half[ch] = !st_reg.half[ch];
					// Every second overflow is one bit
					st_next.bit_p[ch] = (ch == 0) ? st_reg.half[ch] : !st_reg.half[ch];
				end else begin
					st_next.cnt[ch] = st_reg.cnt[ch] + 8'h01;
				end
			end
		end
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign tx_bit = st_reg.bit_p[0];
	assign rx_bit = st_reg.bit_p[1];
endmodule

// [hdl/asp_pkg.sv]
// Shared constants and types of the asynchronous serial port
package asp_pkg;
	// Register byte addresses
	localparam logic [7:0] ADDR_CTRL  = 8'h00;
	localparam logic [7:0] ADDR_DATA  = 8'h04;
	localparam logic [7:0] ADDR_CFG   = 8'h08;
	localparam logic [7:0] ADDR_STAT  = 8'h0C;
	// Control register bit positions
	localparam int BIT_MODE  = 7;
	localparam int BIT_ONE   = 6;
	localparam int BIT_MCE   = 5;
	localparam int BIT_REN   = 4;
	localparam int BIT_TB8   = 3;
	localparam int BIT_RB8   = 2;
	localparam int BIT_TI    = 1;
	localparam int BIT_RI    = 0;
	// Configuration register fields
	localparam int BIT_IRQEN = 0;
	localparam int BIT_TEN   = 1;
	localparam int SEL_LO    = 2;
	localparam int SEL_HI    = 4;
	localparam int RLD_LO    = 8;
	localparam int RLD_HI    = 15;
	// Status register bit positions
	localparam int BIT_TXBSY = 0;
	localparam int BIT_RXBSY = 1;
	// Baud timer clock sources
	localparam logic [2:0] SEL_DIV4  = 3'h0;
	localparam logic [2:0] SEL_DIV12 = 3'h1;
	localparam logic [2:0] SEL_DIV48 = 3'h2;
	localparam logic [2:0] SEL_OSC8  = 3'h3;
	localparam logic [2:0] SEL_EXT   = 3'h4;
	// Prescale terminal counts (divide minus one)
	localparam logic [5:0] LAST_DIV4  = 6'h03;
	localparam logic [5:0] LAST_DIV12 = 6'h0B;
	localparam logic [5:0] LAST_DIV48 = 6'h2F;
	localparam logic [2:0] LAST_OSC8  = 3'h7;
	// Timer overflow value and last data bit index
	localparam logic [7:0] TMR_TOP    = 8'hFF;
	localparam logic [2:0] LAST_BIT   = 3'h7;
	localparam logic [7:0] RST_BYTE   = 8'h00;
	localparam logic [31:0] RST_WORD  = 32'h0000_0000;
	// Serial frame sequence states
	typedef enum logic [2:0] {ST_IDLE, ST_START, ST_DATA, ST_NINTH, ST_STOP} asp_seq_t;
	// Baud generator configuration
	typedef struct packed {
		logic       timer_en;  // Timer runs
		logic [2:0] clk_sel;   // Timer clock source
		logic [7:0] reload;    // Auto-reload byte
	} asp_baud_cfg_t;
	// External timer clock pins
	typedef struct packed {
		logic osc;             // External oscillator
		logic count;           // External count input
	} asp_ext_t;
endpackage

// [hdl/asp_prescale.sv]
// Baud timer clock source selection and prescaling
`timescale 1ns/1ps
module asp_prescale (
	// Clock and reset
	input  wire logic               pclk,
	input  wire logic               presetn,
	// Selection and pins
	input  wire asp_pkg::asp_baud_cfg_t cfg,
	input  wire asp_pkg::asp_ext_t  ext,
	// Timer clock pulse
	output logic                    tick
);
	// Module state
	typedef struct packed {
		logic [5:0] cnt;       // System clock divider
		logic [2:0] osc_cnt;   // Oscillator edge divider
		logic       osc_prev;  // Oscillator last level
		logic       cnt_prev;  // Count input last level
		logic       tick;      // Registered pulse
	} asp_pre_st_t;
	asp_pre_st_t st_reg, st_next;
	logic [5:0]  last;         // Active terminal count

	// Next state of the dividers
	always_comb begin
		st_next = st_reg;
		st_next.tick = 1'b0;
		st_next.osc_prev = ext.osc;
		st_next.cnt_prev = ext.count;
		case (cfg.clk_sel)
			asp_pkg::SEL_DIV12: last = asp_pkg::LAST_DIV12;
			asp_pkg::SEL_DIV48: last = asp_pkg::LAST_DIV48;
			default:            last = asp_pkg::LAST_DIV4;
		endcase
		case (cfg.clk_sel)
			// Oscillator rising edges, one pulse per eight
			asp_pkg::SEL_OSC8: begin
				if (ext.osc && !st_reg.osc_prev) begin
					st_next.osc_cnt = st_reg.osc_cnt + 3'h1;
					st_next.tick = (st_reg.osc_cnt == asp_pkg::LAST_OSC8);
				end
			end
			// Each rising edge of the count input
			asp_pkg::SEL_EXT: st_next.tick = ext.count && !st_reg.cnt_prev;
			// System clock division
			default: begin
				if (st_reg.cnt >= last) begin
					st_next.cnt = 6'h00;
					st_next.tick = 1'b1;
				end else begin
					st_next.cnt = st_reg.cnt + 6'h01;
				end
			end
		endcase
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign tick = st_reg.tick;
endmodule

// [hdl/asp_uart.sv]
// Serial port top: APB registers, transmitter and receiver
// How it works
// - Data writes transmit, reads return receive buffer
// - Receive shifter separate from software buffer
// - Flags raise interrupt; only software clears
// - Timer low byte and hidden copy time bits
// - Each timer overflow stream halved into bits
// - Receive copy runs with timer, same reload
// - Start bit reloads the receive copy
// - Timer clock: system_clock/4,/12,/48, osc/8, pin
// - Overflow rate is clock over 256-reload
// - Mode bit picks 8-bit or 9-bit frames
// - 8-bit frame: start, eight LSB-first, stop
// - 8-bit mode stores stop bit as ninth
// - Data write starts; done flag at stop
// - Reception only while receive enable set
// - 8-bit accept: flag clear, filter needs stop
// - Overrun keeps first byte, drops later ones
// - 9-bit frame adds software ninth bit
// - 9-bit mode stores ninth, ignores stop
// - 9-bit accept: flag clear, filter needs ninth
`timescale 1ns/1ps
module asp_uart (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	// Serial lines
	input  wire logic        serial_rx_line,
	output logic             serial_tx_line,
	// Timer clock pins
	input  wire logic        ext_osc_in,
	input  wire logic        external_count_input,
	// Interrupt request
	output logic             uart_irq
);
	// Whole module state
	typedef struct packed {
		logic               pready;       // Access phase answer
		logic               pslverr;      // Unmapped address
		logic [31:0]        prdata;       // Read data
		logic               irq;          // Interrupt output
		logic               frame_mode_select;     // 9-bit frames
		logic               address_filter_enable; // Address filter
		logic               rx_enable_bit; // Receiver enable
		logic               ninth_tx_bit; // Ninth bit to send
		logic               ninth_rx_bit; // Ninth bit received
		logic               tx_done_flag; // Transmit done
		logic               rx_done_flag; // Receive done
		logic               irq_en;       // Interrupt enable
		asp_pkg::asp_baud_cfg_t bcfg;     // Baud timer setup
		logic               txd;          // Transmit line
		asp_pkg::asp_seq_t  tx_state;     // Transmit sequence
		logic [2:0]         tx_cnt;       // Transmit bit index
		logic [7:0]         tx_shift;     // Transmit shifter
		logic               tx_pend;      // Byte waiting to go
		asp_pkg::asp_seq_t  rx_state;     // Receive sequence
		logic [2:0]         rx_cnt;       // Receive bit index
		logic [7:0]         rx_shift;     // Receive shifter
		logic               rx_nine;      // Received ninth bit
		logic               rx_prev;      // Last line level
		logic [7:0]         rx_buf;       // Software receive buffer
	} asp_st_t;
	asp_st_t st_reg, st_next;

	logic           tick;           // Timer clock pulse
	logic           tx_bit;         // Transmit bit time
	logic           rx_bit;         // Receive sample time
	logic           rx_restart;     // Start bit seen
	logic           acc_first;      // First access cycle
	logic           commit;         // Transfer completes
	logic           wr;             // Committed write
	logic           tx_done_set;    // Hardware sets transmit flag
	logic           rx_done_set;    // Hardware sets receive flag
	logic           rx_keybit;      // Bit checked by the filter
	logic           rx_accept;      // Frame goes to the buffer
	asp_pkg::asp_ext_t ext;         // Timer pin group

	assign ext = '{osc: ext_osc_in, count: external_count_input};

	// Timer clock source
	asp_prescale u_pre (
		.pclk    (pclk),
		.presetn (presetn),
		.cfg     (st_reg.bcfg),
		.ext     (ext),
		.tick    (tick)
	);

	// Transmit and receive bit timing
	asp_baud_timer u_baud (
		.pclk       (pclk),
		.presetn    (presetn),
		.cfg        (st_reg.bcfg),
		.tick       (tick),
		.rx_restart (rx_restart),
		.tx_bit     (tx_bit),
		.rx_bit     (rx_bit)
	);

	// Bus phase decode
	assign acc_first = psel && penable && !st_reg.pready;
	assign commit    = psel && penable && st_reg.pready;
	assign wr        = commit && pwrite && !st_reg.pslverr;

	// Next state of the whole block
	always_comb begin
		st_next = st_reg;
		tx_done_set = 1'b0;
		rx_done_set = 1'b0;
		rx_restart = 1'b0;
		rx_keybit = 1'b0;
		rx_accept = 1'b0;
		st_next.rx_prev = serial_rx_line;

		// Bus answer: one wait cycle, then pready
		st_next.pready = acc_first;
		if (acc_first) begin
			st_next.pslverr = 1'b0;
			st_next.prdata = asp_pkg::RST_WORD;
			case (paddr)
				// Control bits, unused bit reads one
				asp_pkg::ADDR_CTRL: begin
					st_next.prdata[asp_pkg::BIT_MODE] = st_reg.frame_mode_select;
					st_next.prdata[asp_pkg::BIT_ONE]  = 1'b1;
					st_next.prdata[asp_pkg::BIT_MCE]  = st_reg.address_filter_enable;
					st_next.prdata[asp_pkg::BIT_REN]  = st_reg.rx_enable_bit;
					st_next.prdata[asp_pkg::BIT_TB8]  = st_reg.ninth_tx_bit;
					st_next.prdata[asp_pkg::BIT_RB8]  = st_reg.ninth_rx_bit;
					st_next.prdata[asp_pkg::BIT_TI]   = st_reg.tx_done_flag;
					st_next.prdata[asp_pkg::BIT_RI]   = st_reg.rx_done_flag;
				end
				// Reads see only the receive buffer
				asp_pkg::ADDR_DATA: st_next.prdata[7:0] = st_reg.rx_buf;
				// Timer setup and interrupt enable
				asp_pkg::ADDR_CFG: begin
					st_next.prdata[asp_pkg::BIT_IRQEN] = st_reg.irq_en;
					st_next.prdata[asp_pkg::BIT_TEN]   = st_reg.bcfg.timer_en;
					st_next.prdata[asp_pkg::SEL_HI:asp_pkg::SEL_LO] = st_reg.bcfg.clk_sel;
					st_next.prdata[asp_pkg::RLD_HI:asp_pkg::RLD_LO] = st_reg.bcfg.reload;
				end
				// Sequencer activity
				asp_pkg::ADDR_STAT: begin
					st_next.prdata[asp_pkg::BIT_TXBSY] = (st_reg.tx_state != asp_pkg::ST_IDLE)
						|| st_reg.tx_pend;
					st_next.prdata[asp_pkg::BIT_RXBSY] = (st_reg.rx_state != asp_pkg::ST_IDLE);
				end
				// Unmapped address
				default: st_next.pslverr = 1'b1;
			endcase
		end else if (commit) begin
			st_next.pslverr = 1'b0;
		end

		// Register writes take effect at the completing edge
		if (wr) begin
			case (paddr)
				// Control register
				asp_pkg::ADDR_CTRL: begin
					st_next.frame_mode_select     = pwdata[asp_pkg::BIT_MODE];
					st_next.address_filter_enable = pwdata[asp_pkg::BIT_MCE];
					st_next.rx_enable_bit         = pwdata[asp_pkg::BIT_REN];
					st_next.ninth_tx_bit          = pwdata[asp_pkg::BIT_TB8];
					st_next.ninth_rx_bit          = pwdata[asp_pkg::BIT_RB8];
					st_next.tx_done_flag          = pwdata[asp_pkg::BIT_TI];
					st_next.rx_done_flag          = pwdata[asp_pkg::BIT_RI];
				end
				// Writes go to the transmitter only
				asp_pkg::ADDR_DATA: begin
					if (st_reg.tx_state == asp_pkg::ST_IDLE && !st_reg.tx_pend) begin
						st_next.tx_shift = pwdata[7:0];
						st_next.tx_pend = 1'b1;
					end
				end
				// Timer setup
				asp_pkg::ADDR_CFG: begin
					st_next.irq_en        = pwdata[asp_pkg::BIT_IRQEN];
					st_next.bcfg.timer_en = pwdata[asp_pkg::BIT_TEN];
					st_next.bcfg.clk_sel  = pwdata[asp_pkg::SEL_HI:asp_pkg::SEL_LO];
					st_next.bcfg.reload   = pwdata[asp_pkg::RLD_HI:asp_pkg::RLD_LO];
				end
				// Status is read only
				default: ;
			endcase
		end

		// Transmit sequence, one step per bit time
		if (tx_bit) begin
			case (st_reg.tx_state)
				// Start bit drives the line low
				asp_pkg::ST_IDLE: begin
					if (st_reg.tx_pend) begin
						st_next.txd = 1'b0;
						st_next.tx_pend = 1'b0;
						st_next.tx_state = asp_pkg::ST_START;
					end
				end
				// First data bit, least significant
				asp_pkg::ST_START: begin
					st_next.txd = st_reg.tx_shift[0];
					st_next.tx_shift = {1'b0, st_reg.tx_shift[7:1]};
					st_next.tx_cnt = 3'h0;
					st_next.tx_state = asp_pkg::ST_DATA;
				end
				// Remaining data bits
				asp_pkg::ST_DATA: begin
					if (st_reg.tx_cnt == asp_pkg::LAST_BIT) begin
						if (st_reg.frame_mode_select) begin
							// Software ninth bit
							st_next.txd = st_reg.ninth_tx_bit;
							st_next.tx_state = asp_pkg::ST_NINTH;
						end else begin
							// Stop bit begins: done flag
							st_next.txd = 1'b1;
							tx_done_set = 1'b1;
							st_next.tx_state = asp_pkg::ST_STOP;
						end
					end else begin
						st_next.txd = st_reg.tx_shift[0];
						st_next.tx_shift = {1'b0, st_reg.tx_shift[7:1]};
						st_next.tx_cnt = st_reg.tx_cnt + 3'h1;
					end
				end
				// Stop bit after the ninth
				asp_pkg::ST_NINTH: begin
					st_next.txd = 1'b1;
					tx_done_set = 1'b1;
					st_next.tx_state = asp_pkg::ST_STOP;
				end
				// Stop bit ends, line stays high
				asp_pkg::ST_STOP: st_next.tx_state = asp_pkg::ST_IDLE;
				default: begin
					st_next.txd = 1'b1;
					st_next.tx_state = asp_pkg::ST_IDLE;
				end
			endcase
		end

		// Receive start detection, falling edge when enabled
		if (st_reg.rx_state == asp_pkg::ST_IDLE) begin
			if (st_reg.rx_enable_bit && st_reg.bcfg.timer_en && st_reg.rx_prev && !serial_rx_line) begin
				rx_restart = 1'b1;
				st_next.rx_state = asp_pkg::ST_START;
			end
		end else if (rx_bit) begin
			case (st_reg.rx_state)
				// Mid start bit: must still be low
				asp_pkg::ST_START: begin
					st_next.rx_cnt = 3'h0;
					st_next.rx_state = serial_rx_line ? asp_pkg::ST_IDLE : asp_pkg::ST_DATA;
				end
				// Shifter fills while the buffer holds the old byte
				asp_pkg::ST_DATA: begin
					st_next.rx_shift = {serial_rx_line, st_reg.rx_shift[7:1]};
					st_next.rx_cnt = st_reg.rx_cnt + 3'h1;
					if (st_reg.rx_cnt == asp_pkg::LAST_BIT) begin
						st_next.rx_state = st_reg.frame_mode_select ? asp_pkg::ST_NINTH : asp_pkg::ST_STOP;
					end
				end
				// Ninth data bit
				asp_pkg::ST_NINTH: begin
					st_next.rx_nine = serial_rx_line;
					st_next.rx_state = asp_pkg::ST_STOP;
				end
				// Stop sample decides acceptance
				asp_pkg::ST_STOP: begin
					// Stop bit in 8-bit mode, ninth in 9-bit
					rx_keybit = st_reg.frame_mode_select ? st_reg.rx_nine : serial_rx_line;
					// Flag clear, filter passes
					rx_accept = !st_reg.rx_done_flag && (!st_reg.address_filter_enable || rx_keybit);
					if (rx_accept) begin
						st_next.rx_buf = st_reg.rx_shift;
						st_next.ninth_rx_bit = rx_keybit;
						rx_done_set = 1'b1;
					end
					// Otherwise first byte kept, frame lost
					st_next.rx_state = asp_pkg::ST_IDLE;
				end
				default: st_next.rx_state = asp_pkg::ST_IDLE;
			endcase
		end

		// Hardware set wins over a software clear
		if (tx_done_set) begin
			st_next.tx_done_flag = 1'b1;
		end
		if (rx_done_set) begin
			st_next.rx_done_flag = 1'b1;
		end
		// Interrupt follows the flags while enabled
		st_next.irq = st_reg.irq_en && (st_reg.tx_done_flag || st_reg.rx_done_flag);
	end

	// State register with reset values
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= '0;
			st_reg.txd <= 1'b1;
			st_reg.rx_prev <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	// Outputs straight from the state register
	assign pready         = st_reg.pready;
	assign prdata         = st_reg.prdata;
	assign pslverr        = st_reg.pslverr;
	assign serial_tx_line = st_reg.txd;
	assign uart_irq       = st_reg.irq;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// Data reads show the receive buffer
	data_read_a: assert property (acc_first && !pwrite && paddr == asp_pkg::ADDR_DATA |=>
		prdata[7:0] == $past(st_reg.rx_buf))
		else $error("data read not from receive buffer");
	// Flag raises the interrupt a cycle later
	irq_raise_a: assert property (st_reg.irq_en && st_reg.rx_done_flag |=> uart_irq)
		else $error("interrupt not raised");
	// Done flag with the stop bit start
	tx_done_a: assert property ($rose(st_reg.tx_state == asp_pkg::ST_STOP) |->
		st_reg.tx_done_flag && serial_tx_line)
		else $error("transmit done not at stop bit");
	// Start bit drives low
	tx_start_a: assert property ($rose(st_reg.tx_state == asp_pkg::ST_START) |-> !serial_tx_line)
		else $error("start bit not low");
	// Ninth bit only in 9-bit mode
	ninth_mode_a: assert property ($rose(st_reg.tx_state == asp_pkg::ST_NINTH) |->
		$past(st_reg.frame_mode_select) && serial_tx_line == $past(st_reg.ninth_tx_bit))
		else $error("ninth bit sent in wrong mode");
	// Idle line high
	tx_idle_a: assert property (st_reg.tx_state == asp_pkg::ST_IDLE |-> serial_tx_line)
		else $error("transmit line not idle high");
	// Disabled receiver stays idle
	rx_enable_a: assert property (!st_reg.rx_enable_bit && st_reg.rx_state == asp_pkg::ST_IDLE |=>
		st_reg.rx_state == asp_pkg::ST_IDLE)
		else $error("receiver ran while disabled");
	// Overrun keeps the first byte
	overrun_a: assert property (st_reg.rx_done_flag ##1 st_reg.rx_done_flag |->
		$stable(st_reg.rx_buf))
		else $error("buffer overwritten on overrun");
	// Filter rejects frames without the key bit
	filter_a: assert property ($rose(st_reg.rx_done_flag) && !$past(wr) && $past(st_reg.address_filter_enable) |->
		st_reg.ninth_rx_bit)
		else $error("filtered frame accepted");
endmodule
